/* inc/pwt_pkg.sv */
// Shared constants, register layout and helpers of the periodic wakeup timer
package pwt_pkg;

  // ==========================================================
  // Bus widths
  localparam int unsigned DATA_W = 32;            // APB data width
  localparam int unsigned ADDR_W = 12;            // APB address width
  localparam int unsigned IVL_W  = 6;             // Interval field width
  localparam int unsigned PRE_W  = 11;            // Prescaler count width

  // ==========================================================
  // Register indices and byte addresses (index times four)
  localparam logic [7:0] IDX_DIV  = 8'h38;        // Prescale value register
  localparam logic [7:0] IDX_WAKE = 8'h39;        // Wakeup interval csr
  localparam logic [7:0] IDX_RST  = 8'h3A;        // Periodic reset csr
  localparam logic [ADDR_W-1:0] ADDR_DIV  = {2'h0, IDX_DIV, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_WAKE = {2'h0, IDX_WAKE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RST  = {2'h0, IDX_RST, 2'h0};

  // ==========================================================
  // Field positions and values
  localparam int unsigned FLAG_BIT = 7;           // Sticky flag bit
  localparam int unsigned ACK_BIT  = 6;           // Write-one acknowledge
  localparam logic [IVL_W-1:0] IVL_RESET  = 6'h3F; // Interval after reset
  localparam logic [IVL_W-1:0] IVL_OFF    = 6'h00; // Disabled interval
  localparam logic [IVL_W-1:0] DIV_POR    = 6'h1F; // Prescale after POR
  localparam logic [IVL_W-1:0] DIV_FORCED = 6'h3F; // Prescale on wake off

  // ==========================================================
  // Prescaler law: base plus step per prescale unit, in slow ticks
  localparam int unsigned PRE_BASE = 504;         // Ticks at value zero
  localparam int unsigned PRE_STEP = 16;          // Ticks per value step

  // Control/status byte layout
  typedef struct packed {
    logic             flag;                       // Sticky event flag
    logic             ack;                        // Acknowledge strobe
    logic [IVL_W-1:0] interval;                   // Interval field
  } pwt_csr_s;

  // Slow ticks per wakeup clock for a prescale value
  function automatic logic [PRE_W-1:0] pwt_pre_limit(
    input logic [IVL_W-1:0] div
  );
    return PRE_W'(PRE_BASE + PRE_STEP * int'(div));
  endfunction

endpackage

/* design/pwt_interval_counter.sv */
// Incrementing interval counter that pulses and wraps at its limit
`timescale 1ns/1ps
`default_nettype none

module pwt_interval_counter #(
  parameter int unsigned WIDTH = 6                // Counter width
) (
  input  wire logic             pclk,             // System clock
  input  wire logic             rst_n,            // Async reset, low
  input  wire logic             tick,             // One count step
  input  wire logic             restart,          // Clear the count
  input  wire logic [WIDTH-1:0] limit,            // Counts per event
  output logic                  hit,              // Limit reached pulse
  output logic      [WIDTH-1:0] count             // Current count
);

  // ==========================================================
  // Count and terminal decode
  logic [WIDTH-1:0] cnt_reg;                      // Running count
  logic [WIDTH-1:0] cnt_next;                     // Next count
  logic [WIDTH-1:0] cnt_inc;                      // Count plus one

  assign cnt_inc = cnt_reg + WIDTH'(1);
  // Event when the step reaches the limit, unless restarted
  assign hit     = tick && !restart && (cnt_inc == limit);
  assign cnt_next = restart ? '0 :
                    hit     ? '0 :
                    tick    ? cnt_inc : cnt_reg;
  assign count   = cnt_reg;

  // Count register
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule // pwt_interval_counter

`default_nettype wire

/* design/pwt_timer.sv */
// Periodic wakeup and reset timer with its APB register slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module pwt_timer
  import pwt_pkg::*;
(
  input  wire logic                      pclk,    // Bus clock
  input  wire logic                      presetn, // Bus reset, low
  input  wire logic                      por_n,   // Power-on reset, low
  input  wire logic                      psel,    // APB select
  input  wire logic                      penable, // APB enable
  input  wire logic                      pwrite,  // APB write
  input  wire logic [pwt_pkg::ADDR_W-1:0] paddr,  // APB address
  input  wire logic [pwt_pkg::DATA_W-1:0] pwdata, // APB write data
  output logic      [pwt_pkg::DATA_W-1:0] prdata, // APB read data
  output logic                           pready,  // APB ready
  output logic                           pslverr, // APB error
  input  wire logic                      slow_tick_in, // Slow clock pin
  output logic                           wake_irq,     // Wake request
  output logic                           periodic_restart_out // Reset
);

  // ==========================================================
  // Reset combination
  logic rst_any_n;                                // Either reset low

  // Power-on reset also counts as a reset of the whole block
  assign rst_any_n = presetn & por_n;

  // ==========================================================
  // Slow clock synchroniser and edge detect
  logic sync1_reg;                                // First stage
  logic sync2_reg;                                // Second stage
  logic sync3_reg;                                // Edge history
  logic slow_rise;                                // Slow clock edge

  // Pin passes two flops before any logic
  always_ff @(posedge pclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= slow_tick_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign slow_rise = sync2_reg & ~sync3_reg;

  // ==========================================================
  // APB decode
  pwt_csr_s          wr_csr;                      // Write data as csr
  logic              setup_ph;                    // Setup cycle
  logic              wr_en;                       // Write takes effect
  logic              hit_div;                     // Prescale selected
  logic              hit_wake;                    // Wake csr selected
  logic              hit_rst;                     // Reset csr selected
  logic              mapped;                      // Any register hit

  assign wr_csr   = pwt_csr_s'(pwdata[7:0]);
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign hit_div  = (paddr == ADDR_DIV);
  assign hit_wake = (paddr == ADDR_WAKE);
  assign hit_rst  = (paddr == ADDR_RST);
  assign mapped   = hit_div | hit_wake | hit_rst;

  // Zero-latency slave: access phase always completes
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // Interval registers and write qualification
  logic [IVL_W-1:0] wake_ivl_reg;                 // Wake interval field
  logic [IVL_W-1:0] rst_ivl_reg;                  // Reset interval field
  logic [IVL_W-1:0] wake_lim_reg;                 // Wake limit in use
  logic [IVL_W-1:0] rst_lim_reg;                  // Reset limit in use
  logic [IVL_W-1:0] div_reg;                      // Prescale value
  logic             wake_wr;                      // Wake csr write
  logic             rst_wr;                       // Reset csr write
  logic             wake_zero_req;                // Zero wake request
  logic             rst_zero_req;                 // Zero reset request
  logic             wake_accept;                  // Wake write allowed
  logic             rst_accept;                   // Reset write allowed
  logic             wake_change;                  // Wake field changes
  logic             rst_change;                   // Reset field changes
  logic             wake_on;                      // Wake enabled
  logic             rst_on;                       // Periodic reset on

  assign wake_wr       = wr_en & hit_wake;
  assign rst_wr        = wr_en & hit_rst;
  assign wake_zero_req = (wr_csr.interval == IVL_OFF);
  assign rst_zero_req  = (wr_csr.interval == IVL_OFF);
  // Never let both sources go silent together
  assign wake_accept = wake_wr &
                       ~(wake_zero_req & (rst_ivl_reg == IVL_OFF));
  assign rst_accept  = rst_wr &
                       ~(rst_zero_req & (wake_ivl_reg == IVL_OFF));
  assign wake_change = wake_accept & (wr_csr.interval != wake_ivl_reg);
  assign rst_change  = rst_accept & (wr_csr.interval != rst_ivl_reg);
  assign wake_on     = (wake_ivl_reg != IVL_OFF);
  assign rst_on      = (rst_ivl_reg != IVL_OFF);

  // Interval fields, reloaded by any reset
  always_ff @(posedge pclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      wake_ivl_reg <= IVL_RESET;
      rst_ivl_reg  <= IVL_RESET;
    end else begin
      if (wake_accept) begin
        wake_ivl_reg <= wr_csr.interval;
      end
      if (rst_accept) begin
        rst_ivl_reg <= wr_csr.interval;
      end
    end
  end

  // Limits in use: a zero field keeps the previous limit running
  always_ff @(posedge pclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      wake_lim_reg <= IVL_RESET;
      rst_lim_reg  <= IVL_RESET;
    end else begin
      if (wake_accept && !wake_zero_req) begin
        wake_lim_reg <= wr_csr.interval;
      end
      if (rst_accept && !rst_zero_req) begin
        rst_lim_reg <= wr_csr.interval;
      end
    end
  end

  // Prescale value survives all but power-on reset
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      div_reg <= DIV_POR;
    end else if (wake_accept && wake_zero_req) begin
      div_reg <= DIV_FORCED;
    end else if (wr_en && hit_div) begin
      div_reg <= wr_csr.interval;
    end
  end

  // ==========================================================
  // Prescaler: slow ticks to one wakeup clock step
  logic [PRE_W-1:0] pre_reg;                      // Slow tick count
  logic [PRE_W-1:0] pre_inc;                      // Count plus one
  logic             wclk_step;                    // Wakeup clock pulse

  assign pre_inc   = pre_reg + PRE_W'(1);
  assign wclk_step = slow_rise & (pre_inc >= pwt_pre_limit(div_reg));

  // Prescaler count
  always_ff @(posedge pclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      pre_reg <= '0;
    end else if (slow_rise) begin
      pre_reg <= wclk_step ? '0 : pre_inc;
    end
  end

  // ==========================================================
  // Cascaded interval counters
  logic             wake_hit;                     // Wake period ended
  logic             rst_hit;                      // Reset period ended
  logic             wake_evt;                     // Wake interrupt event
  logic             rst_evt;                      // Periodic reset event

  // Wake counter steps on each wakeup clock
  pwt_interval_counter #(
    .WIDTH   (IVL_W)
  ) u_wake_cnt (
    .pclk    (pclk),
    .rst_n   (rst_any_n),
    .tick    (wclk_step),
    .restart (wake_change),
    .limit   (wake_lim_reg),
    .hit     (wake_hit),
    .count   ()
  );

  // Reset counter steps on each wake period
  pwt_interval_counter #(
    .WIDTH   (IVL_W)
  ) u_rst_cnt (
    .pclk    (pclk),
    .rst_n   (rst_any_n),
    .tick    (wake_hit),
    .restart (rst_change),
    .limit   (rst_lim_reg),
    .hit     (rst_hit),
    .count   ()
  );

  assign rst_evt  = rst_hit & rst_on;
  // Reset wins over an interrupt in the same cycle
  assign wake_evt = wake_hit & wake_on & ~rst_evt;

  // ==========================================================
  // Sticky flags
  logic wake_flag_reg;                            // Wake flag
  logic wake_flag_next;                           // Next wake flag
  logic prf_reg;                                  // Periodic flag
  logic prf_next;                                 // Next periodic flag
  logic wake_ack;                                 // Wake acknowledge
  logic prf_ack;                                  // Periodic acknowledge

  // Only the acknowledge bit clears; flag bit writes are ignored
  assign wake_ack = wake_wr & wr_csr.ack;
  assign prf_ack  = rst_wr & wr_csr.ack;
  assign wake_flag_next = wake_evt | (wake_flag_reg & ~wake_ack);
  assign prf_next       = rst_evt | (prf_reg & ~prf_ack);

  // Wake flag cleared by any reset
  always_ff @(posedge pclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      wake_flag_reg <= 1'b0;
    end else begin
      wake_flag_reg <= wake_flag_next;
    end
  end

  // Periodic flag cleared by power-on reset only
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      prf_reg <= 1'b0;
    end else begin
      prf_reg <= prf_next;
    end
  end

  // Periodic reset request pulse, one cycle per event
  always_ff @(posedge pclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      periodic_restart_out <= 1'b0;
    end else begin
      periodic_restart_out <= rst_evt;
    end
  end

  // Wake request follows the flag with no mask
  assign wake_irq = wake_flag_reg;

  // ==========================================================
  // Read data, captured in the setup cycle
  pwt_csr_s          rd_wake;                     // Wake csr read view
  pwt_csr_s          rd_rst;                      // Reset csr read view
  logic [7:0]        rd_byte;                     // Selected read byte

  // Acknowledge bits always read zero
  assign rd_wake = '{flag: wake_flag_reg, ack: 1'b0,
                     interval: wake_ivl_reg};
  assign rd_rst  = '{flag: prf_reg, ack: 1'b0, interval: rst_ivl_reg};
  assign rd_byte = hit_wake ? 8'(rd_wake) :
                   hit_rst  ? 8'(rd_rst)  :
                   hit_div  ? {2'h0, div_reg} : 8'h00;

  // Read data register
  always_ff @(posedge pclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      prdata <= '0;
    end else if (setup_ph) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

endmodule // pwt_timer

`default_nettype wire

/* testbench/pwt_timer_properties.sv */
// Port checker of the periodic wakeup timer and its bind
`timescale 1ns/1ps
`default_nettype none

module pwt_timer_checker
  import pwt_pkg::*;
(
  input wire logic                       pclk,    // Clock
  input wire logic                       presetn, // Reset
  input wire logic                       por_n,   // Power-on reset
  input wire logic                       psel,    // Select
  input wire logic                       penable, // Enable
  input wire logic                       pwrite,  // Write
  input wire logic [pwt_pkg::ADDR_W-1:0] paddr,   // Address
  input wire logic [pwt_pkg::DATA_W-1:0] pwdata,  // Write data
  input wire logic [pwt_pkg::DATA_W-1:0] prdata,  // Read data
  input wire logic                       pready,  // Ready
  input wire logic                       pslverr, // Error
  input wire logic                       slow_tick_in,        // Slow pin
  input wire logic                       wake_irq,            // Wake
  input wire logic                       periodic_restart_out // Restart
);
  // ==========================================================
  // Helper decode and slow edge age
  logic       tick_prev_reg;  // Slow pin last cycle
  logic [3:0] since_reg;      // Cycles since slow rise
  wire logic  rise     = slow_tick_in & ~tick_prev_reg;
  wire logic  acc      = psel & penable;
  wire logic  ack_wake = acc & pwrite & (paddr == ADDR_WAKE) & pwdata[6];
  wire logic  rd_csr   = acc & ~pwrite & (paddr == ADDR_WAKE |
                         paddr == ADDR_RST);
  wire logic  mapped   = paddr == ADDR_DIV | paddr == ADDR_WAKE |
                         paddr == ADDR_RST;

  // Age saturates so a quiet slow clock can be recognised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_prev_reg <= 1'b0;
      since_reg     <= 4'hF;
    end else begin
      tick_prev_reg <= slow_tick_in;
      since_reg     <= rise ? 4'h0 :
                       (since_reg == 4'hF ? 4'hF : since_reg + 4'h1);
    end
  end

  // ==========================================================
  // Properties
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);

  a_wake_rise_cause: assert property (
    $rose(wake_irq) |-> since_reg < 4'h7)
    else $error("wake request rose without a slow tick");
  a_wake_flag_holds: assert property (
    wake_irq && !ack_wake |=> wake_irq)
    else $error("wake request dropped without acknowledge");
  a_wake_ack_clears: assert property (
    ack_wake && since_reg > 4'h6 |=> !wake_irq)
    else $error("wake acknowledge did not clear");
  a_csr_ack_zero: assert property (
    rd_csr |-> prdata[6] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("acknowledge bit read back nonzero");
  a_restart_cause: assert property (
    periodic_restart_out |-> since_reg < 4'h7)
    else $error("restart pulse without a slow tick");
  a_restart_single: assert property (
    periodic_restart_out |=> !periodic_restart_out)
    else $error("restart pulse longer than a cycle");
  a_restart_wins: assert property (
    periodic_restart_out |-> !$rose(wake_irq))
    else $error("wake raised with restart");
  a_reset_quiet: assert property (
    $rose(presetn) |-> !wake_irq && !periodic_restart_out)
    else $error("outputs active after reset");
  a_unmapped_err: assert property (acc |-> pslverr == !mapped)
    else $error("error response wrong");
  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase not completed at once");

  c_wake: cover property ($rose(wake_irq));
  c_restart: cover property (periodic_restart_out);
  c_ack: cover property (ack_wake && wake_irq);
endmodule // pwt_timer_checker

bind pwt_timer pwt_timer_checker pwt_timer_checker_inst (
  .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .slow_tick_in(slow_tick_in), .wake_irq(wake_irq),
  .periodic_restart_out(periodic_restart_out));
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench of the periodic wakeup timer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pwt_pkg::*;
  localparam int TP   = 12;           // Clocks per slow tick
  localparam int STEP = PRE_BASE * TP; // Clocks per wake step, prescale 0
  logic              pclk    = 1'b0;   // Clock
  logic              presetn = 1'b0;   // Reset
  logic              por_n   = 1'b0;   // Power-on reset
  logic              psel    = 1'b0;   // Select
  logic              penable = 1'b0;   // Enable
  logic              pwrite  = 1'b0;   // Write
  logic [ADDR_W-1:0] paddr   = '0;     // Address
  logic [DATA_W-1:0] pwdata  = '0;     // Write data
  logic [DATA_W-1:0] prdata;           // Read data
  logic              pready;           // Ready
  logic              pslverr;          // Error
  logic              slow    = 1'b0;   // Slow clock pin
  logic              tick_on = 1'b0;   // Slow clock running
  logic              wake;             // Wake request
  logic              prst;             // Restart pulse
  int                miscompares = 0;  // Mismatches
  int                checked     = 0;  // Comparisons
  int                cyc         = 0;  // Clock count
  int                phase       = 0;  // Slow tick phase

  pwt_timer pwt_timer_inst (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_tick_in(slow), .wake_irq(wake), .periodic_restart_out(prst));

  // Clock and short-high slow tick
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc   <= cyc + 1;
    phase <= (phase == TP - 1) ? 0 : phase + 1;
    slow  <= tick_on && phase < 2;
  end

  // ==========================================================
  // Shared tasks
  task automatic ck(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    ck(r === {24'h0, x} && e === 1'b0, "read value");
  endtask

  // Wait for wake or restart, give the clock count seen
  task automatic wait_hi(input logic rs, input int lim, output int t);
    int n;
    n = 0;
    // Step off the edge so a pulse launched there is not raced
    #1;
    while ((rs ? prst : wake) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    t = cyc;
    ck(n < lim, "event late");
    @(posedge pclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_vals();
    logic [31:0] r;
    logic        e;
    rd(ADDR_WAKE, 8'h3F);
    rd(ADDR_RST, 8'h3F);
    rd(ADDR_DIV, 8'h1F);
    apb(1'b0, 12'h0F0, 8'h00, r, e);
    ck(e === 1'b1 && r === 32'h0, "unmapped");
  endtask

  task automatic t_zero_rules();
    wr(ADDR_WAKE, 8'h00);
    rd(ADDR_WAKE, 8'h00);
    rd(ADDR_DIV, 8'h3F);
    wr(ADDR_RST, 8'h00);
    rd(ADDR_RST, 8'h3F);
    wr(ADDR_WAKE, 8'h01);
    wr(ADDR_RST, 8'h00);
    rd(ADDR_RST, 8'h00);
    wr(ADDR_WAKE, 8'h00);
    rd(ADDR_WAKE, 8'h01);
    wr(ADDR_RST, 8'h02);
  endtask

  task automatic t_events();
    int t1;
    int t2;
    wr(ADDR_DIV, 8'h00);
    tick_on <= 1'b1;
    wait_hi(1'b0, STEP + 64, t1);
    rd(ADDR_WAKE, 8'h81);
    wr(ADDR_WAKE, 8'h01);
    ck(wake === 1'b1, "flag lost");
    wr(ADDR_WAKE, 8'h41);
    ck(wake === 1'b0, "ack ignored");
    wait_hi(1'b1, STEP, t2);
    ck(t2 - t1 == STEP, "period");
    ck(wake === 1'b0, "wake with restart");
    rd(ADDR_RST, 8'h82);
    wr(ADDR_RST, 8'h02);
    rd(ADDR_RST, 8'h82);
    wait_hi(1'b0, STEP + 64, t1);
    ck(t1 - t2 == STEP, "wake after restart");
  endtask

  task automatic t_soft_reset();
    ck(wake === 1'b1, "flag before reset");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ck(wake === 1'b0, "flag kept by reset");
    rd(ADDR_WAKE, 8'h3F);
    rd(ADDR_RST, 8'hBF);
    rd(ADDR_DIV, 8'h00);
    wr(ADDR_RST, 8'h7F);
    rd(ADDR_RST, 8'h3F);
  endtask

  task automatic t_restart();
    int t0;
    int t;
    wr(ADDR_WAKE, 8'h02);
    t0 = cyc;
    repeat (STEP * 3 / 2) @(posedge pclk);
    wr(ADDR_WAKE, 8'h03);
    repeat (STEP) @(posedge pclk);
    wr(ADDR_WAKE, 8'h03);
    while (cyc - t0 < STEP * 7 / 2) @(posedge pclk);
    ck(wake === 1'b0, "early wake");
    wait_hi(1'b0, STEP, t);
    tick_on <= 1'b0;
    repeat (16) @(posedge pclk);
    wr(ADDR_WAKE, 8'h43);
    ck(wake === 1'b0, "ack ignored");
  endtask

  // ==========================================================
  // Verdict and run control
  task automatic final_report();
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    @(posedge pclk);
    t_reset_vals();
    t_zero_rules();
    t_events();
    t_soft_reset();
    t_restart();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
